// [rdtc_pkg.sv]
// Constants and types shared by the datagram transmit control block
package rdtc_pkg;

  // Clock and bit timing
  localparam int unsigned CLK_PERIOD_NS = 50;
  localparam int unsigned BIT_TIME_NS   = 104167;
  localparam int unsigned BIT_CYCLES    = BIT_TIME_NS / CLK_PERIOD_NS;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_FRAME_LEN = 8'h31;
  localparam logic [7:0] IDX_TX_CTRL   = 8'h32;
  localparam logic [7:0] IDX_BANK_LO   = 8'h38;
  localparam logic [7:0] IDX_BANK_HI   = 8'h3b;
  localparam logic [7:0] IDX_BUF_LO    = 8'h20;
  localparam logic [7:0] IDX_BUF_HI    = 8'h2f;
  localparam logic [7:0] IDX_STATUS    = 8'h40;

  // Reset values
  localparam logic [7:0] FRAME_LEN_RST = 8'h00;
  localparam logic [7:0] TX_CTRL_RST   = 8'h00;
  localparam logic [7:0] BANK_RST      = 8'h00;

  // Status register fields
  localparam int unsigned ST_ERR_BIT    = 0;
  localparam int unsigned ST_BUSY_BIT   = 1;
  localparam int unsigned ST_RFRST_BIT  = 4;

  // Tail length in bit times
  localparam logic [1:0] TAIL_BITS = 2'h2;

  // Transmit control register layout
  typedef struct packed {
    logic       send;
    logic       page;
    logic       end_of_message_tail;
    logic [4:0] power;
  } rdtc_tx_ctrl_t;

  // Serializer states
  typedef enum logic [1:0] {
    st_off,
    st_data,
    st_tail
  } rdtc_state_t;

endpackage

// [rdtc_sync2.sv]
// Two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ns
module rdtc_sync2 #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Data
  input  wire logic [WIDTH-1:0] d,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;

  // First stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule

// [rdtc_bit_timer.sv]
// Bit-time tick generator for the serializer
`timescale 1ns/1ns
module rdtc_bit_timer #(
  parameter int unsigned CYCLES = 2
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Control
  input  wire logic run,
  output logic      tick
);

  logic [19:0] cnt_reg;

  // Restart on every idle cycle so the first bit gets a full period
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 20'h00000;
    end else if (!run || tick) begin
      cnt_reg <= 20'h00000;
    end else begin
      cnt_reg <= cnt_reg + 20'h00001;
    end
  end

  assign tick = run && (cnt_reg == 20'(CYCLES - 1));

endmodule

// [rdtc_top.sv]
// Datagram transmit control: registers, data buffer and serializer
// Overview of operation
// - Each datagram carries the frame bit count plus one bits.
// - A frame bit count of zero sends nothing even when started.
// - The RF-module reset clears the frame bit count.
// - Writing one to the start bit sends the buffer for that count.
// - The start bit clears itself at the end and on RF-module reset.
// - Writing zero to the start bit aborts a running transmission.
// - The start bit reads one from its write until the datagram ends or stops.
// - Page select maps the sixteen buffer registers to a half.
// - Page select also picks the bank of registers 0x38 to 0x3b.
// - Page select is cleared by the MCU reset only.
// - With the tail option set two data-one bit times follow.
// - The RF-module reset clears the tail option.
// - The power code drives the amplifier level, zero is low power.
// - The RF-module reset clears the power code.
// - A fault stops the output, clears start and sets the error flag.
// - The RF-module reset idles the serializer, keeping the buffer.
//
// Design decision made here: the APB register port.
`timescale 1ns/1ns
module rdtc_top #(
  parameter int unsigned BIT_CYCLES = rdtc_pkg::BIT_CYCLES
) (
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [11:0] paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Asynchronous pins
  input  wire logic        rf_reset_req,
  input  wire logic        tx_fault,
  // RF front end
  output logic             rf_enable,
  output logic             rf_data,
  output logic      [4:0]  power_level_code,
  output logic             page_select,
  output logic             tx_done
);

  rdtc_pkg::rdtc_tx_ctrl_t ctrl_reg;
  rdtc_pkg::rdtc_state_t   state_reg;
  logic [7:0]  frame_len_reg;
  logic [7:0]  buf_mem [0:31];
  logic [7:0]  bank_mem [0:7];
  logic [8:0]  bit_idx_reg;
  logic [1:0]  tail_cnt_reg;
  logic        err_flag_reg;
  logic        rf_data_reg;
  logic [31:0] prdata_reg;
  logic        slverr_reg;
  logic        rst_req_s;
  logic        fault_s;
  logic        tick;
  logic        rf_rst;
  logic        setup;
  logic        wr_en;
  logic        wr_ctrl;
  logic        running;
  logic        last_bit;
  logic        start_ok;
  logic        fin;
  logic [7:0]  idx;
  logic [31:0] rd_next;
  logic        err_next;

  // Register index of a byte address, zero when misaligned
  function automatic logic [7:0] reg_index(input logic [11:0] a);
    return (a[11:10] == 2'h0 && a[1:0] == 2'h0) ? a[9:2] : 8'h00;
  endfunction
  // Buffer slot for a data register under a given page
  function automatic logic [4:0] buf_slot(input logic pg,
                                          input logic [7:0] i);
    return {pg, i[3:0]};
  endfunction
  // Bank slot for the paged register window
  function automatic logic [2:0] bank_slot(input logic pg,
                                           input logic [7:0] i);
    return {pg, i[1:0]};
  endfunction
  // Buffer bit by serial index, most significant bit of a byte first
  function automatic logic bit_at(input logic [8:0] i);
    return buf_mem[i[7:3]][3'h7 - i[2:0]];
  endfunction

  // Pins from outside the clock domain
  rdtc_sync2 #(
    .WIDTH (2)
  ) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     ({rf_reset_req, tx_fault}),
    .q     ({rst_req_s, fault_s})
  );

  // Bit-time ticks while the serializer runs
  rdtc_bit_timer #(
    .CYCLES (BIT_CYCLES)
  ) u_timer (
    .clk   (pclk),
    .rst_n (presetn),
    .run   (running),
    .tick  (tick)
  );

  // Bus decode; zero wait states, data registered in setup
  assign setup   = psel && !penable;
  assign wr_en   = psel && penable && pwrite && !slverr_reg;
  assign idx     = reg_index(paddr);
  assign wr_ctrl = wr_en && idx == rdtc_pkg::IDX_TX_CTRL;
  assign pready  = 1'b1;
  assign prdata  = prdata_reg;
  assign pslverr = psel && penable && slverr_reg;

  // Module reset from the pin or a software command
  assign rf_rst = rst_req_s || (wr_en && idx == rdtc_pkg::IDX_STATUS
                  && pwdata[rdtc_pkg::ST_RFRST_BIT]);

  // Serializer status terms
  assign running  = state_reg != rdtc_pkg::st_off;
  assign last_bit = bit_idx_reg == {1'b0, frame_len_reg};
  assign start_ok = state_reg == rdtc_pkg::st_off && ctrl_reg.send;
  assign fin = (start_ok && frame_len_reg == 8'h00)
    || (state_reg == rdtc_pkg::st_data && tick && last_bit && !ctrl_reg.end_of_message_tail)
    || (state_reg == rdtc_pkg::st_tail && tick
        && tail_cnt_reg == rdtc_pkg::TAIL_BITS - 2'h1);

  // Read mux, chained address decode
  always_comb begin
    rd_next  = 32'h00000000;
    err_next = 1'b0;
    if (idx == rdtc_pkg::IDX_FRAME_LEN) begin
      rd_next[7:0] = frame_len_reg;
    end else if (idx == rdtc_pkg::IDX_TX_CTRL) begin
      rd_next[7:0] = ctrl_reg;
    end else if (idx >= rdtc_pkg::IDX_BUF_LO
                 && idx <= rdtc_pkg::IDX_BUF_HI) begin
      rd_next[7:0] = buf_mem[buf_slot(ctrl_reg.page, idx)];
    end else if (idx >= rdtc_pkg::IDX_BANK_LO
                 && idx <= rdtc_pkg::IDX_BANK_HI) begin
      rd_next[7:0] = bank_mem[bank_slot(ctrl_reg.page, idx)];
    end else if (idx == rdtc_pkg::IDX_STATUS) begin
      rd_next[rdtc_pkg::ST_ERR_BIT]  = err_flag_reg;
      rd_next[rdtc_pkg::ST_BUSY_BIT] = running;
    end else begin
      err_next = 1'b1;
    end
  end

  // Answer captured in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h00000000;
      slverr_reg <= 1'b0;
    end else if (setup) begin
      prdata_reg <= pwrite ? 32'h00000000 : rd_next;
      slverr_reg <= err_next;
    end
  end

  // Frame bit count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frame_len_reg <= rdtc_pkg::FRAME_LEN_RST;
    end else if (rf_rst) begin
      frame_len_reg <= rdtc_pkg::FRAME_LEN_RST;
    end else if (wr_en && idx == rdtc_pkg::IDX_FRAME_LEN) begin
      frame_len_reg <= pwdata[7:0];
    end
  end

  // Page select survives the module reset, only the MCU reset clears it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg.page <= rdtc_pkg::TX_CTRL_RST[6];
    end else if (wr_ctrl) begin
      ctrl_reg.page <= pwdata[6];
    end
  end

  // Tail option and power code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg.end_of_message_tail   <= rdtc_pkg::TX_CTRL_RST[5];
      ctrl_reg.power <= rdtc_pkg::TX_CTRL_RST[4:0];
    end else if (rf_rst) begin
      ctrl_reg.end_of_message_tail   <= rdtc_pkg::TX_CTRL_RST[5];
      ctrl_reg.power <= rdtc_pkg::TX_CTRL_RST[4:0];
    end else if (wr_ctrl) begin
      ctrl_reg.end_of_message_tail   <= pwdata[5];
      ctrl_reg.power <= pwdata[4:0];
    end
  end

  // Start bit; a new start written in the finishing cycle wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg.send <= rdtc_pkg::TX_CTRL_RST[7];
    end else if (rf_rst) begin
      ctrl_reg.send <= 1'b0;
    end else if (fault_s && ctrl_reg.send) begin
      ctrl_reg.send <= 1'b0;
    end else if (wr_ctrl) begin
      ctrl_reg.send <= pwdata[7];
    end else if (fin) begin
      ctrl_reg.send <= 1'b0;
    end
  end

  // Error flag, set wins over the write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      err_flag_reg <= 1'b0;
    end else if (fault_s && ctrl_reg.send && !rf_rst) begin
      err_flag_reg <= 1'b1;
    end else if (wr_en && idx == rdtc_pkg::IDX_STATUS
                 && pwdata[rdtc_pkg::ST_ERR_BIT]) begin
      err_flag_reg <= 1'b0;
    end
  end

  // Data buffer has no reset so the module reset leaves it intact
  always_ff @(posedge pclk) begin
    if (wr_en && idx >= rdtc_pkg::IDX_BUF_LO
        && idx <= rdtc_pkg::IDX_BUF_HI) begin
      buf_mem[buf_slot(ctrl_reg.page, idx)] <= pwdata[7:0];
    end
  end

  // Paged register window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < 8; i++) begin
        bank_mem[i] <= rdtc_pkg::BANK_RST;
      end
    end else if (wr_en && idx >= rdtc_pkg::IDX_BANK_LO
                 && idx <= rdtc_pkg::IDX_BANK_HI) begin
      bank_mem[bank_slot(ctrl_reg.page, idx)] <= pwdata[7:0];
    end
  end

  // Serializer; abort and fault take one cycle to drop the carrier
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg    <= rdtc_pkg::st_off;
      bit_idx_reg  <= 9'h000;
      tail_cnt_reg <= 2'h0;
      rf_data_reg  <= 1'b0;
    end else if (rf_rst || (running && !ctrl_reg.send)) begin
      state_reg   <= rdtc_pkg::st_off;
      rf_data_reg <= 1'b0;
    end else begin
      case (state_reg)
        rdtc_pkg::st_off: begin
          if (start_ok && frame_len_reg != 8'h00) begin
            state_reg   <= rdtc_pkg::st_data;
            bit_idx_reg <= 9'h000;
            rf_data_reg <= bit_at(9'h000);
          end
        end
        rdtc_pkg::st_data: begin
          if (tick && last_bit && ctrl_reg.end_of_message_tail) begin
            state_reg    <= rdtc_pkg::st_tail;
            tail_cnt_reg <= 2'h0;
            rf_data_reg  <= 1'b1;
          end else if (tick && last_bit) begin
            state_reg   <= rdtc_pkg::st_off;
            rf_data_reg <= 1'b0;
          end else if (tick) begin
            bit_idx_reg <= bit_idx_reg + 9'h001;
            rf_data_reg <= bit_at(bit_idx_reg + 9'h001);
          end
        end
        rdtc_pkg::st_tail: begin
          if (fin) begin
            state_reg   <= rdtc_pkg::st_off;
            rf_data_reg <= 1'b0;
          end else if (tick) begin
            tail_cnt_reg <= tail_cnt_reg + 2'h1;
          end
        end
        default: begin
          state_reg <= rdtc_pkg::st_off;
        end
      endcase
    end
  end

  // Outputs toward the RF front end
  assign rf_enable        = running;
  assign rf_data          = rf_data_reg;
  assign power_level_code = ctrl_reg.power;
  assign page_select      = ctrl_reg.page;
  assign tx_done          = fin && !rf_rst && !(fault_s && ctrl_reg.send);

  // Helper: data bit times counted independently of the serializer
  logic [8:0] chk_ticks_reg;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chk_ticks_reg <= 9'h000;
    end else if (state_reg != rdtc_pkg::st_data) begin
      chk_ticks_reg <= 9'h000;
    end else if (tick) begin
      chk_ticks_reg <= chk_ticks_reg + 9'h001;
    end
  end
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_quiet;
    !rf_rst && !fault_s && !wr_ctrl;
  endsequence
  sequence s_data_end;
    state_reg == rdtc_pkg::st_data && tick && last_bit && ctrl_reg.send;
  endsequence
  chk_bit_count: assert property (
    s_data_end and s_quiet |-> chk_ticks_reg == {1'b0, frame_len_reg})
    else $error("datagram bit count differs from frame length plus one");
  chk_zero_length: assert property (
    start_ok && frame_len_reg == 8'h00 && !wr_ctrl
    |=> !ctrl_reg.send && !rf_enable)
    else $error("zero frame length still transmitted");
  chk_reset_frame: assert property (
    rf_rst |=> frame_len_reg == 8'h00)
    else $error("frame length kept across module reset");
  chk_start_run: assert property (
    (start_ok && frame_len_reg != 8'h00) and s_quiet
    |=> state_reg == rdtc_pkg::st_data ##0 rf_enable)
    else $error("start did not begin transmission");
  chk_send_clear: assert property (
    fin and s_quiet |=> !ctrl_reg.send ##1 !rf_enable)
    else $error("start bit not cleared at end of datagram");
  chk_abort_stop: assert property (
    running && wr_ctrl && !pwdata[7] && !rf_rst |=> ##1 !rf_enable)
    else $error("abort did not stop transmission");
  chk_read_busy: assert property (
    setup && !pwrite && idx == rdtc_pkg::IDX_TX_CTRL
    |=> prdata[7] == $past(ctrl_reg.send))
    else $error("start bit read back wrong");
  chk_page_keep: assert property (
    rf_rst && !wr_ctrl |=> $stable(ctrl_reg.page))
    else $error("page select changed by module reset");
  chk_tail_level: assert property (
    s_data_end and s_quiet |=> ctrl_reg.end_of_message_tail
      ? (state_reg == rdtc_pkg::st_tail && rf_data)
      : !rf_enable)
    else $error("tail bit times wrong");
  chk_reset_ctrl: assert property (
    rf_rst |=> ctrl_reg.power == 5'h00 && !ctrl_reg.end_of_message_tail
      && !ctrl_reg.send)
    else $error("module reset left control fields set");
  chk_fault_stop: assert property (
    fault_s && ctrl_reg.send && !rf_rst
    |=> !ctrl_reg.send && err_flag_reg ##1 !rf_enable)
    else $error("fault did not stop transmission");
  chk_reset_idle: assert property (
    rf_rst |=> state_reg == rdtc_pkg::st_off && !rf_data)
    else $error("serializer not idle after module reset");
  // Start bit must still be set, an abort idles the line instead
  chk_serial_order: assert property (
    (state_reg == rdtc_pkg::st_data && tick && !last_bit && ctrl_reg.send)
    and s_quiet
    |=> rf_data == bit_at($past(bit_idx_reg) + 9'h001))
    else $error("serial bit order wrong");

endmodule

// [rdtc_rx_model.sv]
// Remote receiver model: samples the carrier once per bit time
`timescale 1ns/1ns
module rdtc_rx_model #(
  parameter int unsigned BITS = 4
) (
  // Clock
  input wire logic pclk,
  // Carrier from the transmitter
  input wire logic rf_enable,
  input wire logic rf_data
);
  logic        bits[$];
  int unsigned ph = 0;

  // Sample mid-bit, away from the bit edges; order kept as received
  always @(posedge pclk) begin
    if (rf_enable) begin
      if (ph % BITS == BITS / 2)
        bits.push_back(rf_data);
      ph <= ph + 1;
    end else begin
      ph <= 0;  // Carrier off ends the datagram
    end
  end
endmodule

// [tb_rf_datagram_tx_control.sv]
// Self-checking bench for the datagram transmit control block
`timescale 1ns/1ns
module tb_rf_datagram_tx_control;
  localparam int unsigned BITS = 4;
  logic        pclk;
  logic        presetn;
  logic [11:0] paddr;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rf_reset_req;
  logic        tx_fault;
  logic        rf_enable;
  logic        rf_data;
  logic [4:0]  power_level_code;
  logic        page_select;
  logic        tx_done;
  int          bad_count = 0;
  int          tests_run = 0;
  logic [31:0] rd;
  logic        err;
  logic [7:0]  buf_b[2];

  rdtc_top #(.BIT_CYCLES(BITS)) rdtc_top_i (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rf_reset_req(rf_reset_req), .tx_fault(tx_fault),
    .rf_enable(rf_enable), .rf_data(rf_data),
    .power_level_code(power_level_code), .page_select(page_select),
    .tx_done(tx_done)
  );

  rdtc_rx_model #(.BITS(BITS)) rdtc_rx_model_i (
    .pclk(pclk), .rf_enable(rf_enable), .rf_data(rf_data)
  );

  // Clock, 50 ns period
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer, then one idle cycle so strobes never double-drive
  task automatic apb(input logic wr, input logic [7:0] idx,
                     input logic [7:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'h0, idx, 2'h0};
    pwdata  <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the watchdog ends a stalled access
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic rd_chk(input logic [7:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(rd, {24'h0, exp});
  endtask

  // Start one datagram and compare what the receiver saw
  task automatic run_frame(input logic [7:0] len, input logic end_of_message_tail,
                           input logic [4:0] pw);
    int n;
    n = 0;
    apb(1'b1, rdtc_pkg::IDX_FRAME_LEN, len);
    rdtc_rx_model_i.bits.delete();
    apb(1'b1, rdtc_pkg::IDX_TX_CTRL, {2'b10, end_of_message_tail, pw});
    chk(32'(power_level_code), 32'(pw));
    rd_chk(rdtc_pkg::IDX_TX_CTRL, {2'b10, end_of_message_tail, pw});
    while (tx_done !== 1'b1 && n < 3000) begin
      n++;
      @(posedge pclk);
    end
    chk(32'(tx_done), 32'h1);
    repeat (2 * BITS) @(posedge pclk);
    chk(32'(rdtc_rx_model_i.bits.size()), 32'(len) + (end_of_message_tail ? 3 : 1));
    for (int k = 0; k <= len; k++) begin
      chk(32'(rdtc_rx_model_i.bits[k]), 32'(buf_b[k/8][7-k%8]));
    end
    if (end_of_message_tail) begin
      chk(32'(rdtc_rx_model_i.bits[len+1]), 32'h1);
      chk(32'(rdtc_rx_model_i.bits[len+2]), 32'h1);
    end
    rd_chk(rdtc_pkg::IDX_TX_CTRL, {2'b00, end_of_message_tail, pw});
  endtask

  // Verdict and end of run
  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Watchdog sized well above the expected run length
  initial begin
    repeat (30000) @(posedge pclk);
    bad_count++;
    end_of_test();
  end

  // Main sequence
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    rf_reset_req = 1'b0;
    tx_fault = 1'b0;
    buf_b[0] = 8'ha5;
    buf_b[1] = 8'h3c;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd_chk(rdtc_pkg::IDX_FRAME_LEN, 8'h00);
    rd_chk(rdtc_pkg::IDX_TX_CTRL, 8'h00);
    // Unmapped place is refused and reads zero
    apb(1'b0, 8'h10, 8'h00);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    // Two pages of buffer and bank registers
    apb(1'b1, rdtc_pkg::IDX_BUF_LO, buf_b[0]);
    apb(1'b1, rdtc_pkg::IDX_BUF_LO + 8'h01, buf_b[1]);
    apb(1'b1, rdtc_pkg::IDX_BANK_LO, 8'h11);
    apb(1'b1, rdtc_pkg::IDX_TX_CTRL, 8'h40);
    chk(32'(page_select), 32'h1);
    apb(1'b1, rdtc_pkg::IDX_BUF_LO, 8'h77);
    apb(1'b1, rdtc_pkg::IDX_BANK_HI, 8'h22);
    rd_chk(rdtc_pkg::IDX_BUF_LO, 8'h77);
    rd_chk(rdtc_pkg::IDX_BANK_LO, 8'h00);
    apb(1'b1, rdtc_pkg::IDX_TX_CTRL, 8'h00);
    rd_chk(rdtc_pkg::IDX_BUF_LO, 8'ha5);
    rd_chk(rdtc_pkg::IDX_BUF_LO + 8'h01, 8'h3c);
    rd_chk(rdtc_pkg::IDX_BANK_LO, 8'h11);
    rd_chk(rdtc_pkg::IDX_BANK_HI, 8'h00);
    // Every power code reaches the amplifier
    for (int c = 0; c < 32; c++) begin
      apb(1'b1, rdtc_pkg::IDX_TX_CTRL, 8'(c));
      chk(32'(power_level_code), 32'(c));
    end
    // Zero length: start is taken but nothing is sent
    apb(1'b1, rdtc_pkg::IDX_TX_CTRL, 8'h80);
    repeat (8) begin
      chk(32'(rf_enable), 32'h0);
      @(posedge pclk);
    end
    rd_chk(rdtc_pkg::IDX_TX_CTRL, 8'h00);
    run_frame(8'h01, 1'b0, 5'h01);
    run_frame(8'h0b, 1'b1, 5'h13);
    // Abort by writing zero to the start bit
    apb(1'b1, rdtc_pkg::IDX_FRAME_LEN, 8'hff);
    apb(1'b1, rdtc_pkg::IDX_TX_CTRL, 8'h80);
    repeat (20) @(posedge pclk);
    chk(32'(rf_enable), 32'h1);
    rd_chk(rdtc_pkg::IDX_STATUS, 8'h02);
    apb(1'b1, rdtc_pkg::IDX_TX_CTRL, 8'h00);
    repeat (2) @(posedge pclk);
    chk(32'(rf_enable), 32'h0);
    // Fault mid-frame: carrier off, start cleared, flag set then cleared
    apb(1'b1, rdtc_pkg::IDX_TX_CTRL, 8'h80);
    repeat (10) @(posedge pclk);
    tx_fault <= 1'b1;
    repeat (6) @(posedge pclk);
    tx_fault <= 1'b0;
    chk(32'(rf_enable), 32'h0);
    rd_chk(rdtc_pkg::IDX_TX_CTRL, 8'h00);
    rd_chk(rdtc_pkg::IDX_STATUS, 8'h01);
    apb(1'b1, rdtc_pkg::IDX_STATUS, 8'h01);
    rd_chk(rdtc_pkg::IDX_STATUS, 8'h00);
    // RF-module reset during a frame keeps page and buffer
    apb(1'b1, rdtc_pkg::IDX_FRAME_LEN, 8'h5a);
    apb(1'b1, rdtc_pkg::IDX_TX_CTRL, 8'hf3);
    repeat (6) @(posedge pclk);
    rf_reset_req <= 1'b1;
    repeat (4) @(posedge pclk);
    rf_reset_req <= 1'b0;
    repeat (4) @(posedge pclk);
    chk(32'(rf_enable), 32'h0);
    rd_chk(rdtc_pkg::IDX_FRAME_LEN, 8'h00);
    rd_chk(rdtc_pkg::IDX_TX_CTRL, 8'h40);
    rd_chk(rdtc_pkg::IDX_BUF_LO, 8'h77);
    // MCU reset clears the page bit
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk(32'(page_select), 32'h0);
    presetn <= 1'b1;
    @(posedge pclk);
    end_of_test();
  end
endmodule
